// file: dv/upip_board.sv
/*
  Board around the port lines: a pull-up on every line and one external
  open-drain driver per line that the bench controls.
  Assumes the pads resolve the line as a wired-AND of all drivers.
*/
`timescale 1ns/1ps
`default_nettype none

module upip_board (
  input  wire logic [31:0] pin_out,
  input  wire logic [31:0] pin_oe,
  input  wire logic [31:0] ext_low,
  output logic [31:0]      pin_in
);
  // ==========================================================================
  // Line resolution
  assign pin_in = ~(pin_oe & ~pin_out) & ~ext_low;
endmodule : upip_board

`default_nettype wire

// file: dv/upip_port_test.sv
/*
  Self-checking bench of the parallel port: register tasks and one task per scenario.
  Assumes the board model pulls idle lines high.
*/
`timescale 1ns/1ps
`default_nettype none

module upip_port_test;
  logic                   clk = 1'b0;
  logic                   nrst, core_clk, wait_o, irq;
  upip_pkg::upip_req_type req;
  logic [31:0]            rdata, pin_out, pin_oe, pin_in, ext_low;
  int                     fails = 0;
  int                     tests_run = 0;
  int                     cycles = 0;

  upip_port upip_port_i (.clk(clk), .nrst(nrst), .bus_req(req), .bus_rdata(rdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .core_clock_src(core_clk),
    .bus_wait_in(wait_o), .irq(irq));
  upip_board upip_board_i (.pin_out(pin_out), .pin_oe(pin_oe), .ext_low(ext_low),
    .pin_in(pin_in));

  always #12.5 clk = ~clk;

  // ==========================================================================
  // Bus and compare helpers
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic chk1(input string what, input logic exp, input logic got);
    check(what, {31'h0, exp}, {31'h0, got});
  endtask : chk1

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    if (what != "")
      check(what, exp, rdata);
  endtask : rd

  task automatic settle;
    repeat (5) @(posedge clk);
    #1;
  endtask : settle

  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    check("pin_oe", 32'h0000_0000, pin_oe);
    chk1("bus_wait_in", 1'b1, wait_o);
    rd(upip_pkg::OFS_OUTPUT_STATUS, 32'h0000_0000, "output_status");
    rd(upip_pkg::OFS_OUTPUT_DATA_STATUS, 32'h0000_0000, "output_data_status");
    rd(upip_pkg::OFS_OPEN_DRAIN_STATUS, 32'h0000_0000, "open_drain_status");
    rd(upip_pkg::OFS_POWER_STATUS, 32'h0000_0000, "power_status");
    rd(upip_pkg::OFS_PIN_FUNCTION_SEL, 32'h0000_0000, "pin_function_select");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_dir_data;
    wr(upip_pkg::OFS_OUTPUT_ENABLE, 32'h0000_00FF);
    wr(upip_pkg::OFS_OUTPUT_DISABLE, 32'h0000_000F);
    wr(upip_pkg::OFS_OUTPUT_ENABLE, 32'h0000_0000);
    rd(upip_pkg::OFS_OUTPUT_STATUS, 32'h0000_00F0, "output_status");
    check("pin_oe", 32'h0000_00F0, pin_oe);
    wr(upip_pkg::OFS_SET_OUTPUT_DATA, 32'h0000_00A5);
    wr(upip_pkg::OFS_CLEAR_OUTPUT_DATA, 32'h0000_0005);
    wr(upip_pkg::OFS_SET_OUTPUT_DATA, 32'h0000_0000);
    rd(upip_pkg::OFS_OUTPUT_DATA_STATUS, 32'h0000_00A0, "output_data_status");
    wr(upip_pkg::OFS_CLOCK_ENABLE, 32'h0000_0001);
    rd(upip_pkg::OFS_POWER_STATUS, 32'h0000_0001, "power_status");
    settle;
    rd(upip_pkg::OFS_PIN_LEVEL_STATUS, 32'hFFFF_FFAF, "pin_level_status");
    $display("t_dir_data done");
  endtask : t_dir_data

  task automatic t_open_drain;
    wr(upip_pkg::OFS_OPEN_DRAIN_ENABLE, 32'h0000_0030);
    rd(upip_pkg::OFS_OPEN_DRAIN_STATUS, 32'h0000_0030, "open_drain_status");
    check("pin_oe", 32'h0000_00D0, pin_oe);
    ext_low <= 32'h0000_0020;
    settle;
    rd(upip_pkg::OFS_PIN_LEVEL_STATUS, 32'hFFFF_FF8F, "pin_level_status");
    ext_low <= 32'h0000_0000;
    wr(upip_pkg::OFS_OPEN_DRAIN_DISABLE, 32'h0000_0030);
    rd(upip_pkg::OFS_OPEN_DRAIN_STATUS, 32'h0000_0000, "open_drain_status");
    check("pin_oe", 32'h0000_00F0, pin_oe);
    $display("t_open_drain done");
  endtask : t_open_drain

  task automatic t_change_irq;
    settle;
    rd(upip_pkg::OFS_CHANGE_STATUS, 32'h0000_0000, "");
    wr(upip_pkg::OFS_IRQ_ENABLE, 32'h0000_0100);
    rd(upip_pkg::OFS_IRQ_MASK, 32'h0000_0100, "irq_mask");
    ext_low <= 32'h0000_0100;
    settle;
    chk1("irq", 1'b1, irq);
    wr(upip_pkg::OFS_CLEAR_OUTPUT_DATA, 32'h0000_0080);
    settle;
    rd(upip_pkg::OFS_CHANGE_STATUS, 32'h0000_0180, "change_status");
    rd(upip_pkg::OFS_CHANGE_STATUS, 32'h0000_0000, "change_status");
    chk1("irq", 1'b0, irq);
    ext_low <= 32'h0000_0000;
    settle;
    chk1("irq", 1'b1, irq);
    wr(upip_pkg::OFS_IRQ_DISABLE, 32'h0000_0100);
    chk1("irq", 1'b0, irq);
    rd(upip_pkg::OFS_IRQ_MASK, 32'h0000_0000, "irq_mask");
    $display("t_change_irq done");
  endtask : t_change_irq

  task automatic t_special;
    wr(upip_pkg::OFS_PIN_FUNCTION_SEL, 32'hC000_0000);
    rd(upip_pkg::OFS_PIN_FUNCTION_SEL, 32'hC000_0000, "pin_function_select");
    wr(upip_pkg::OFS_OUTPUT_ENABLE, 32'hC000_0000);
    chk1("line 30 enable", 1'b0, pin_oe[30]);
    core_clk <= 1'b1;
    @(posedge clk);
    #1;
    chk1("line 31 clock high", 1'b1, pin_out[31]);
    core_clk <= 1'b0;
    ext_low <= 32'h4000_0000;
    settle;
    chk1("line 31 clock low", 1'b0, pin_out[31]);
    chk1("bus_wait_in", 1'b0, wait_o);
    wr(upip_pkg::OFS_PIN_FUNCTION_SEL, 32'h0000_0000);
    core_clk <= 1'b1;
    settle;
    chk1("bus_wait_in", 1'b1, wait_o);
    chk1("line 31 port data", 1'b0, pin_out[31]);
    ext_low <= 32'h0000_0000;
    $display("t_special done");
  endtask : t_special

  task automatic t_map;
    rd(8'h00, 32'h0000_0000, "reserved 0x00");
    rd(8'h1C, 32'h0000_0000, "reserved 0x1C");
    rd(8'h4C, 32'h0000_0000, "reserved 0x4C");
    rd(8'h68, 32'h0000_0000, "reserved 0x68");
    wr(upip_pkg::OFS_OUTPUT_STATUS, 32'hFFFF_FFFF);
    rd(upip_pkg::OFS_OUTPUT_STATUS, 32'hC000_00F0, "output_status");
    $display("t_map done");
  endtask : t_map

  task automatic t_clock;
    settle;
    rd(upip_pkg::OFS_CHANGE_STATUS, 32'h0000_0000, "");
    wr(upip_pkg::OFS_CLOCK_DISABLE, 32'h0000_0001);
    rd(upip_pkg::OFS_POWER_STATUS, 32'h0000_0000, "power_status");
    ext_low <= 32'h0000_0002;
    settle;
    rd(upip_pkg::OFS_CHANGE_STATUS, 32'h0000_0000, "change_status");
    $display("t_clock done");
  endtask : t_clock

  task automatic t_soft_reset;
    wr(upip_pkg::OFS_CLOCK_ENABLE, 32'h0000_0001);
    wr(upip_pkg::OFS_IRQ_ENABLE, 32'h0000_0003);
    wr(upip_pkg::OFS_PIN_FUNCTION_SEL, 32'h8000_0000);
    wr(upip_pkg::OFS_CONTROL, 32'h0000_0001);
    rd(upip_pkg::OFS_OUTPUT_STATUS, 32'h0000_0000, "output_status");
    rd(upip_pkg::OFS_OUTPUT_DATA_STATUS, 32'h0000_0000, "output_data_status");
    rd(upip_pkg::OFS_IRQ_MASK, 32'h0000_0000, "irq_mask");
    rd(upip_pkg::OFS_PIN_FUNCTION_SEL, 32'h0000_0000, "pin_function_select");
    rd(upip_pkg::OFS_POWER_STATUS, 32'h0000_0001, "power_status");
    check("pin_oe", 32'h0000_0000, pin_oe);
    $display("t_soft_reset done");
  endtask : t_soft_reset

  // ==========================================================================
  // Verdict and hang guard
  task automatic summarize;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      summarize;
    end
  end

  initial
  begin
    nrst = 1'b0;
    core_clk = 1'b0;
    ext_low = 32'h0000_0000;
    req = '0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    t_reset;
    t_dir_data;
    t_open_drain;
    t_change_irq;
    t_special;
    t_map;
    t_clock;
    t_soft_reset;
    summarize;
  end
endmodule : upip_port_test

`default_nettype wire

// file: hdl/upip_pkg.sv
/*
  Package of the unified parallel I/O port: register offsets, reset values,
  field positions and the bus request carrier.
  Assumes a 32-bit register port with byte offsets on an 8-bit address.
*/
`default_nettype none

package upip_pkg;

  // ==========================================================================
  // Widths
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned LINES   = 32;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_OUTPUT_ENABLE      = 8'h10;
  localparam logic [7:0] OFS_OUTPUT_DISABLE     = 8'h14;
  localparam logic [7:0] OFS_OUTPUT_STATUS      = 8'h18;
  localparam logic [7:0] OFS_SET_OUTPUT_DATA    = 8'h30;
  localparam logic [7:0] OFS_CLEAR_OUTPUT_DATA  = 8'h34;
  localparam logic [7:0] OFS_OUTPUT_DATA_STATUS = 8'h38;
  localparam logic [7:0] OFS_PIN_LEVEL_STATUS   = 8'h3C;
  localparam logic [7:0] OFS_OPEN_DRAIN_ENABLE  = 8'h40;
  localparam logic [7:0] OFS_OPEN_DRAIN_DISABLE = 8'h44;
  localparam logic [7:0] OFS_OPEN_DRAIN_STATUS  = 8'h48;
  localparam logic [7:0] OFS_CLOCK_ENABLE       = 8'h50;
  localparam logic [7:0] OFS_CLOCK_DISABLE      = 8'h54;
  localparam logic [7:0] OFS_POWER_STATUS       = 8'h58;
  localparam logic [7:0] OFS_CONTROL            = 8'h60;
  localparam logic [7:0] OFS_PIN_FUNCTION_SEL   = 8'h64;
  localparam logic [7:0] OFS_CHANGE_STATUS      = 8'h70;
  localparam logic [7:0] OFS_IRQ_ENABLE         = 8'h74;
  localparam logic [7:0] OFS_IRQ_DISABLE        = 8'h78;
  localparam logic [7:0] OFS_IRQ_MASK           = 8'h7C;

  // ==========================================================================
  // Field positions
  localparam int unsigned CORE_CLK_SEL_BIT = 31;
  localparam int unsigned BUS_WAIT_SEL_BIT = 30;
  localparam int unsigned CLOCK_ON_BIT     = 0;
  localparam int unsigned SOFT_RESET_BIT   = 0;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] RST_OUTPUT_STATUS  = 32'h0000_0000;
  localparam logic [31:0] RST_OUTPUT_DATA    = 32'h0000_0000;
  localparam logic [31:0] RST_OPEN_DRAIN     = 32'h0000_0000;
  localparam logic        RST_POWER_STATUS   = 1'b0;
  localparam logic [1:0]  RST_PIN_FUNCTION   = 2'h0;
  localparam logic [31:0] RST_CHANGE_STATUS  = 32'h0000_0000;
  localparam logic [31:0] RST_IRQ_MASK       = 32'h0000_0000;
  localparam logic [31:0] RST_READ_DATA      = 32'h0000_0000;
  localparam logic [31:0] RST_PIN_LEVEL      = 32'h0000_0000;

  // ==========================================================================
  // Bus request carrier
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } upip_req_type;

endpackage : upip_pkg

`default_nettype wire

// file: hdl/upip_port.sv
/*
  Unified parallel I/O port: 32 lines with direction, output data, open-drain,
  clock gating, change detection with masked interrupt, and two special
  functions on lines 30 and 31.
  Assumes a single-cycle register master on clk and pads that resolve the
  line level from pin_out and pin_oe with an external pull-up.
*/
// How it works
// [R1] Function bit 31 set routes core clock onto line 31 instead of port.
// [R2] Function bit 30 set connects line 30 to the bus wait input.
// [R3] Ones to output enable make lines outputs; ones to disable make inputs.
// [R4] Output status shows one per output line; all inputs after reset.
// [R5] Ones to set data program one; ones to clear data program zero.
// [R6] Output data status returns programmed data, zero after reset.
// [R7] Pin level status returns the synchronized level on every line, sampled only while the clock is on.
// [R8] Open drain enable makes lines open drain; disable restores push-pull.
// [R9] Open drain status shows one per open-drain line, zero after reset.
// [R10] Clock enable and disable bit 0 gate the port; power status shows it.
// [R11] Registers decode at fixed offsets; gaps are reserved and read zero.
// [R12] Any level change on a line while the clock is on sets its change status bit.
// [R13] Reading change status clears its set bits.
// [R14] Interrupt asserts for a set status bit whose mask bit is enabled.
// [R15] Open-drain lines drive only low and release otherwise, except line 31 while function bit 31 routes the core clock onto it.
// [R16] Zero bits written to set/clear pairs leave the line unchanged.
`timescale 1ns/1ps
`default_nettype none

module upip_port (
  input  wire logic                  clk,
  input  wire logic                  nrst,
  input  wire upip_pkg::upip_req_type bus_req,
  output logic [31:0]                bus_rdata,
  input  wire logic [31:0]           pin_in,
  output logic [31:0]                pin_out,
  output logic [31:0]                pin_oe,
  input  wire logic                  core_clock_src,
  output logic                       bus_wait_in,
  output logic                       irq
);

  // ==========================================================================
  // State
  logic [31:0] dir_ff;
  logic [31:0] odata_ff;
  logic [31:0] od_ff;
  logic        clk_on_ff;
  logic [1:0]  func_ff;
  logic [31:0] chg_ff;
  logic [31:0] mask_ff;
  logic [31:0] sync1_ff;
  logic [31:0] sync2_ff;
  logic [31:0] level_ff;
  logic [31:0] rdata_ff;

  logic [31:0] nxt_dir;
  logic [31:0] nxt_odata;
  logic [31:0] nxt_od;
  logic        nxt_clk_on;
  logic [1:0]  nxt_func;
  logic [31:0] nxt_chg;
  logic [31:0] nxt_mask;
  logic [31:0] nxt_level;
  logic [31:0] nxt_rdata;

  // ==========================================================================
  // Address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  wire logic        wr       = bus_req.wr;
  wire logic        rd       = bus_req.rd;
  wire logic [7:0]  a        = bus_req.addr;
  wire logic [31:0] wd       = bus_req.wdata;

  wire logic wr_oen   = wr & hit(a, upip_pkg::OFS_OUTPUT_ENABLE);      // [R11]
  wire logic wr_odis  = wr & hit(a, upip_pkg::OFS_OUTPUT_DISABLE);
  wire logic wr_dset  = wr & hit(a, upip_pkg::OFS_SET_OUTPUT_DATA);
  wire logic wr_dclr  = wr & hit(a, upip_pkg::OFS_CLEAR_OUTPUT_DATA);
  wire logic wr_oden  = wr & hit(a, upip_pkg::OFS_OPEN_DRAIN_ENABLE);
  wire logic wr_oddis = wr & hit(a, upip_pkg::OFS_OPEN_DRAIN_DISABLE);
  wire logic wr_cken  = wr & hit(a, upip_pkg::OFS_CLOCK_ENABLE);
  wire logic wr_ckdis = wr & hit(a, upip_pkg::OFS_CLOCK_DISABLE);
  wire logic wr_ctrl  = wr & hit(a, upip_pkg::OFS_CONTROL);
  wire logic wr_func  = wr & hit(a, upip_pkg::OFS_PIN_FUNCTION_SEL);
  wire logic wr_ien   = wr & hit(a, upip_pkg::OFS_IRQ_ENABLE);
  wire logic wr_idis  = wr & hit(a, upip_pkg::OFS_IRQ_DISABLE);
  wire logic rd_chg   = rd & hit(a, upip_pkg::OFS_CHANGE_STATUS);

  // Software reset clears all but the power status and the pin level status
  wire logic soft_rst = wr_ctrl & wd[upip_pkg::SOFT_RESET_BIT];

  wire logic clk_sel  = func_ff[1];
  wire logic wait_sel = func_ff[0];

  // ==========================================================================
  // Next-state logic
  wire logic [31:0] change = clk_on_ff ? (sync2_ff ^ level_ff) : 32'h0000_0000;   // [R12]

  assign nxt_dir    = soft_rst ? upip_pkg::RST_OUTPUT_STATUS :
                      (dir_ff | (wr_oen ? wd : 32'h0000_0000))
                      & ~(wr_odis ? wd : 32'h0000_0000);                // [R3] [R16]
  assign nxt_odata  = soft_rst ? upip_pkg::RST_OUTPUT_DATA :
                      (odata_ff | (wr_dset ? wd : 32'h0000_0000))
                      & ~(wr_dclr ? wd : 32'h0000_0000);                // [R5] [R16]
  assign nxt_od     = soft_rst ? upip_pkg::RST_OPEN_DRAIN :
                      (od_ff | (wr_oden ? wd : 32'h0000_0000))
                      & ~(wr_oddis ? wd : 32'h0000_0000);               // [R8] [R16]
  assign nxt_clk_on = (clk_on_ff | (wr_cken & wd[upip_pkg::CLOCK_ON_BIT]))
                      & ~(wr_ckdis & wd[upip_pkg::CLOCK_ON_BIT]);       // [R10]
  assign nxt_func   = soft_rst ? upip_pkg::RST_PIN_FUNCTION :
                      wr_func ? {wd[upip_pkg::CORE_CLK_SEL_BIT], wd[upip_pkg::BUS_WAIT_SEL_BIT]}
                              : func_ff;
  assign nxt_mask   = soft_rst ? upip_pkg::RST_IRQ_MASK :
                      (mask_ff | (wr_ien ? wd : 32'h0000_0000))
                      & ~(wr_idis ? wd : 32'h0000_0000);                // [R14] [R16]
  // A change in the read cycle survives the clear
  assign nxt_chg    = ((soft_rst | rd_chg) ? 32'h0000_0000 : chg_ff) | change;  // [R13]
  assign nxt_level  = clk_on_ff ? sync2_ff : level_ff;

  // ==========================================================================
  // Read mux
  logic [31:0] rd_val;
  always_comb
  begin
    rd_val = 32'h0000_0000;                                             // [R11]
    unique case (a)
      upip_pkg::OFS_OUTPUT_STATUS:      rd_val = dir_ff;                // [R4]
      upip_pkg::OFS_OUTPUT_DATA_STATUS: rd_val = odata_ff;              // [R6]
      upip_pkg::OFS_PIN_LEVEL_STATUS:   rd_val = level_ff;              // [R7]
      upip_pkg::OFS_OPEN_DRAIN_STATUS:  rd_val = od_ff;                 // [R9]
      upip_pkg::OFS_POWER_STATUS:       rd_val = {31'h0, clk_on_ff};    // [R10]
      upip_pkg::OFS_PIN_FUNCTION_SEL:   rd_val = {func_ff, 30'h0};
      upip_pkg::OFS_CHANGE_STATUS:      rd_val = chg_ff;
      upip_pkg::OFS_IRQ_MASK:           rd_val = mask_ff;
      default:                          rd_val = 32'h0000_0000;
    endcase
  end
  assign nxt_rdata = rd ? rd_val : upip_pkg::RST_READ_DATA;

  // ==========================================================================
  // Registers
  always_ff @(posedge clk)
  begin
    sync1_ff <= pin_in;
    sync2_ff <= sync1_ff;
  end

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      dir_ff    <= upip_pkg::RST_OUTPUT_STATUS;                         // [R4]
      odata_ff  <= upip_pkg::RST_OUTPUT_DATA;
      od_ff     <= upip_pkg::RST_OPEN_DRAIN;
      clk_on_ff <= upip_pkg::RST_POWER_STATUS;
      func_ff   <= upip_pkg::RST_PIN_FUNCTION;
      chg_ff    <= upip_pkg::RST_CHANGE_STATUS;
      mask_ff   <= upip_pkg::RST_IRQ_MASK;
      level_ff  <= upip_pkg::RST_PIN_LEVEL;
      rdata_ff  <= upip_pkg::RST_READ_DATA;
    end
    else
    begin
      dir_ff    <= nxt_dir;
      odata_ff  <= nxt_odata;
      od_ff     <= nxt_od;
      clk_on_ff <= nxt_clk_on;
      func_ff   <= nxt_func;
      chg_ff    <= nxt_chg;
      mask_ff   <= nxt_mask;
      level_ff  <= nxt_level;
      rdata_ff  <= nxt_rdata;
    end
  end

  // ==========================================================================
  // Pin drive
  wire logic [31:0] pp_oe   = dir_ff & ~od_ff;
  wire logic [31:0] od_oe   = dir_ff & od_ff & ~odata_ff;               // [R15]
  wire logic [31:0] line_oe = pp_oe | od_oe;
  wire logic [31:0] line_do = odata_ff & ~od_ff;                        // [R15]

  always_comb
  begin
    pin_oe  = line_oe;
    pin_out = line_do;
    if (clk_sel)
    begin
      pin_out[31] = core_clock_src;                                     // [R1]
      pin_oe[31]  = dir_ff[31];
    end
    if (wait_sel)
    begin
      pin_out[30] = 1'b0;                                               // [R2]
      pin_oe[30]  = 1'b0;
    end
  end

  assign bus_wait_in = wait_sel ? sync2_ff[30] : 1'b1;                  // [R2]
  assign irq         = |(chg_ff & mask_ff);                             // [R14]
  assign bus_rdata   = rdata_ff;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  dir_set_a: assert property (wr_oen |=> (dir_ff & $past(wd)) == $past(wd))   // [R3]
    else $error("output enable did not set direction");
  dir_clr_a: assert property (wr_odis |=> (dir_ff & $past(wd)) == 32'h0)      // [R3]
    else $error("output disable did not clear direction");
  data_keep_a: assert property (wr_dset && !soft_rst
      |=> (odata_ff & ~$past(wd)) == ($past(odata_ff) & ~$past(wd)))          // [R16]
    else $error("zero bits of set data changed a line");
  data_clr_a: assert property (wr_dclr |=> (odata_ff & $past(wd)) == 32'h0)   // [R5]
    else $error("clear data did not clear");
  od_low_a: assert property (((pin_oe & pin_out & od_ff) & ~{clk_sel, 31'h0}) == 32'h0) // [R15]
    else $error("open drain line driven high");
  chg_set_a: assert property (change != 32'h0 |=> (chg_ff & $past(change)) == $past(change)) // [R12]
    else $error("change not flagged");
  rc_read_a: assert property (rd_chg ##1 1'b1 |-> bus_rdata == $past(chg_ff)
      && chg_ff == $past(change))                                             // [R13]
    else $error("change status read did not clear");
  irq_mask_a: assert property (irq == ((chg_ff & mask_ff) != 32'h0))          // [R14]
    else $error("interrupt not tied to masked status");
  clk_route_a: assert property (clk_sel && dir_ff[31] |-> pin_oe[31]
      && pin_out[31] == core_clock_src)                                       // [R1]
    else $error("core clock not routed");
  wait_route_a: assert property (wait_sel |-> !pin_oe[30]
      && bus_wait_in == sync2_ff[30])                                         // [R2]
    else $error("wait input not routed");
  pwr_a: assert property (wr_cken && wd[0] && !wr_ckdis ##1 !wr_ckdis
      ##1 rd && a == upip_pkg::OFS_POWER_STATUS |=> bus_rdata[0])             // [R10]
    else $error("power status not set after enable");
  soft_rst_a: assert property (soft_rst |=> dir_ff == 32'h0 && odata_ff == 32'h0
      && od_ff == 32'h0 && mask_ff == 32'h0 && func_ff == 2'h0
      && clk_on_ff == $past(clk_on_ff))                                       // [R4]
    else $error("software reset left state behind");

  rd_chg_c: cover property (rd_chg && chg_ff != 32'h0);
  od_line_c: cover property (od_oe != 32'h0);
  clk_out_c: cover property (clk_sel && dir_ff[31]);
  irq_c: cover property (irq);
  soft_rst_c: cover property (soft_rst && dir_ff != 32'h0);

endmodule : upip_port

`default_nettype wire
